//--- core/flic_top.sv
// Purpose: Four-level vectored interrupt controller for an 8-bit core
// Assumes: Peripheral requests synchronous to clk_i; external pins asynchronous
// Notes:   Core signals boundary and return-from-service as one-cycle pulses
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module flic_top
  import flic_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [3:0]          addr_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [7:0]          rdata_o,
  input  wire logic [NSRC-1:0]     periph_req_i,
  input  wire logic [1:0]          ext_irq_pin_n_i,
  input  wire logic                boundary_i,
  input  wire logic                reti_i,
  input  wire logic                sleeping_i,
  output logic                     vec_valid_o,
  output logic [SRC_W-1:0]         vec_idx_o,
  output logic                     wake_o,
  output logic                     irq_o
);
  // Register state
  logic [7:0]          irq_enable_reg_a_reg;
  logic [7:0]          irq_enable_reg_b_reg;
  logic [7:0]          irq_level_low_a_reg;
  logic [7:0]          irq_level_high_a_reg;
  logic [7:0]          irq_level_low_b_reg;
  logic [7:0]          irq_level_high_b_reg;
  logic [1:0]          ext_trigger_sel_reg;
  logic [1:0]          ext_request_flag_reg;
  logic [NSTAT-1:0]    stat_reg;
  logic [NSTAT-1:0]    mask_reg;
  logic [NLVL-1:0]     active_reg;
  logic [1:0]          sync1_reg;
  logic [1:0]          sync2_reg;
  logic [1:0]          samp_reg;
  logic                mc_reg;
  logic [NSRC-1:0]     pend_reg;
  logic [7:0]          rdata_reg;
  logic                vec_valid_reg;
  logic [SRC_W-1:0]    vec_idx_reg;
  logic                wake_reg;
  logic                irq_reg;

  logic [NSRC-1:0]     enable;
  logic [NSRC-1:0]     raw_req;
  logic [NSRC-1:0]     elig;
  logic [2*NSRC-1:0]   lvl_flat;
  logic                arb_hit;
  logic [SRC_W-1:0]    arb_idx;
  logic [LVL_W-1:0]    arb_lvl;
  logic                take;
  logic [1:0]          edge_seen;
  logic [1:0]          clr_edge;
  logic [NSTAT-1:0]    stat_set;

  // Per-source enable and level from the two register pairs
  assign enable = {irq_enable_reg_b_reg, irq_enable_reg_a_reg[SPLIT-1:0]};
  generate
    for (genvar g = 0; g < NSRC; g++) begin : g_lvl
      if (g < SPLIT) begin : g_a
        assign lvl_flat[2*g +: 2] = {irq_level_high_a_reg[g], irq_level_low_a_reg[g]};
      end else begin : g_b
        assign lvl_flat[2*g +: 2] = {irq_level_high_b_reg[g-SPLIT], irq_level_low_b_reg[g-SPLIT]};
      end
    end
  endgenerate

  // Requests: externals from their flags or pins, the rest from peripherals
  always_comb begin
    raw_req = periph_req_i;
    for (int k = 0; k < 2; k++) begin
      raw_req[2*k] = ext_trigger_sel_reg[k] ? ext_request_flag_reg[k] : ~sync2_reg[k];
    end
  end

  // Enabled and gated requests
  assign elig = pend_reg & enable & {NSRC{irq_enable_reg_a_reg[GATE_BIT]}};

  flic_arbiter #(
    .N (NSRC)
  ) u_arb (
    .req_i (elig),
    .lvl_i (lvl_flat),
    .hit_o (arb_hit),
    .idx_o (arb_idx),
    .lvl_o (arb_lvl)
  );

  // Vector only when the winner beats every active level
  always_comb begin
    take = arb_hit && boundary_i && !active_reg[NLVL-1];
    for (int l = 0; l < NLVL; l++) begin
      if (active_reg[l] && int'(arb_lvl) <= l) begin
        take = 1'b0;
      end
    end
  end

  // Two-flop synchroniser for the external pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
    end else begin
      sync1_reg <= ext_irq_pin_n_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Machine-cycle phase; pins and requests sampled once per machine cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mc_reg   <= 1'b0;
      samp_reg <= 2'h3;
      pend_reg <= '0;
    end else begin
      mc_reg <= ~mc_reg;
      if (mc_reg) begin
        samp_reg <= sync2_reg;
        pend_reg <= raw_req;
      end
    end
  end

  // Falling edge between two samples
  assign edge_seen = {2{mc_reg}} & samp_reg & ~sync2_reg;
  always_comb begin
    clr_edge = 2'h0;
    if (wr_i && addr_i == ADDR_TEC) begin
      clr_edge = {~wdata_i[TEC_IE1], ~wdata_i[TEC_IE0]};
    end
    if (take) begin
      if (arb_idx == SRC_W'(0)) clr_edge[0] = 1'b1;
      if (arb_idx == SRC_W'(2)) clr_edge[1] = 1'b1;
    end
  end

  // External edge flags: set wins over clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_request_flag_reg <= 2'h0;
    end else begin
      ext_request_flag_reg <= (ext_request_flag_reg & ~clr_edge) | (edge_seen & ext_trigger_sel_reg);
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_enable_reg_a_reg <= RST_BYTE;
      irq_enable_reg_b_reg <= RST_BYTE;
      irq_level_low_a_reg  <= RST_BYTE;
      irq_level_high_a_reg <= RST_BYTE;
      irq_level_low_b_reg  <= RST_BYTE;
      irq_level_high_b_reg <= RST_BYTE;
      ext_trigger_sel_reg  <= 2'h0;
      mask_reg             <= '0;
    end else if (wr_i) begin
      unique case (addr_i)
        ADDR_ENA_A:    irq_enable_reg_a_reg <= wdata_i;
        ADDR_ENA_B:    irq_enable_reg_b_reg <= wdata_i;
        ADDR_LVL_LO_A: irq_level_low_a_reg  <= wdata_i;
        ADDR_LVL_HI_A: irq_level_high_a_reg <= wdata_i;
        ADDR_LVL_LO_B: irq_level_low_b_reg  <= wdata_i;
        ADDR_LVL_HI_B: irq_level_high_b_reg <= wdata_i;
        ADDR_TEC:      ext_trigger_sel_reg  <= {wdata_i[TEC_IT1], wdata_i[TEC_IT0]};
        ADDR_MASK:     mask_reg             <= wdata_i[NSTAT-1:0];
        default:       ;
      endcase
    end
  end

  // Active-level stack: set on vector, clear highest on return
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_reg <= '0;
    end else if (take) begin
      active_reg[arb_lvl] <= 1'b1;
    end else if (reti_i) begin
      for (int l = 0; l < NLVL; l++) begin
        if (active_reg[l] && (active_reg >> (l + 1)) == '0) begin
          active_reg[l] <= 1'b0;
        end
      end
    end
  end

  // Vector and wake outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_valid_reg <= 1'b0;
      vec_idx_reg   <= '0;
      wake_reg      <= 1'b0;
    end else begin
      vec_valid_reg <= take;
      if (take) begin
        vec_idx_reg <= arb_idx;
      end
      wake_reg <= sleeping_i && (|elig);
    end
  end

  // Sticky status, set wins over write-one-to-clear
  assign stat_set = {|edge_seen, sleeping_i && (|elig), take};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      if (wr_i && addr_i == ADDR_STAT) begin
        stat_reg <= (stat_reg & ~wdata_i[NSTAT-1:0]) | stat_set;
      end else begin
        stat_reg <= stat_reg | stat_set;
      end
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        ADDR_ENA_A:    rdata_reg <= irq_enable_reg_a_reg;
        ADDR_ENA_B:    rdata_reg <= irq_enable_reg_b_reg;
        ADDR_LVL_LO_A: rdata_reg <= irq_level_low_a_reg;
        ADDR_LVL_HI_A: rdata_reg <= irq_level_high_a_reg;
        ADDR_LVL_LO_B: rdata_reg <= irq_level_low_b_reg;
        ADDR_LVL_HI_B: rdata_reg <= irq_level_high_b_reg;
        ADDR_TEC:      rdata_reg <= {4'h0, ext_request_flag_reg[1], ext_trigger_sel_reg[1],
                                     ext_request_flag_reg[0], ext_trigger_sel_reg[0]};
        ADDR_STAT:     rdata_reg <= {5'h00, stat_reg};
        ADDR_MASK:     rdata_reg <= {5'h00, mask_reg};
        ADDR_SVC:      rdata_reg <= {active_reg, vec_idx_reg};
        default:       rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata_o     = rdata_reg;
  assign vec_valid_o = vec_valid_reg;
  assign vec_idx_o   = vec_idx_reg;
  assign wake_o      = wake_reg;
  assign irq_o       = irq_reg;
endmodule

//--- core/flic_pkg.sv
// Purpose: Constants for the four-level interrupt controller
// Assumes: 125 MHz clock, register port with one-cycle read latency
// Notes:   Overview of operation
package flic_pkg;
  localparam int NSRC      = 15;
  localparam int NLVL      = 4;
  localparam int LVL_W     = 2;
  localparam int SRC_W     = 4;
  localparam int DEPTH_W   = 3;
  // Register addresses
  localparam logic [3:0] ADDR_ENA_A    = 4'h0; // bit7 global gate, bits6:0 sources 0..6
  localparam logic [3:0] ADDR_ENA_B    = 4'h1; // bits7:0 sources 7..14
  localparam logic [3:0] ADDR_LVL_LO_A = 4'h2;
  localparam logic [3:0] ADDR_LVL_HI_A = 4'h3;
  localparam logic [3:0] ADDR_LVL_LO_B = 4'h4;
  localparam logic [3:0] ADDR_LVL_HI_B = 4'h5;
  localparam logic [3:0] ADDR_TEC      = 4'h6; // bit0/2 trig sel, bit1/3 edge flags
  localparam logic [3:0] ADDR_STAT     = 4'h7; // sticky event bits, write one to clear
  localparam logic [3:0] ADDR_MASK     = 4'h8;
  localparam logic [3:0] ADDR_SVC      = 4'h9; // read: active level bits, current vector
  localparam int GATE_BIT   = 7;
  localparam int SPLIT      = 7;
  localparam int TEC_IT0    = 0;
  localparam int TEC_IE0    = 1;
  localparam int TEC_IT1    = 2;
  localparam int TEC_IE1    = 3;
  localparam int STAT_VEC   = 0; // vectored
  localparam int STAT_WAKE  = 1; // wake raised
  localparam int STAT_EDGE  = 2; // external edge seen
  localparam int NSTAT      = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int MC_CLKS    = 2; // clocks per machine cycle
endpackage

//--- core/flic_arbiter.sv
// Purpose: Pick the highest-level pending source, ties by lowest index
// Assumes: Pure combinational, same clock domain as caller
// Notes:   Index order is the polling order
`timescale 1ns/1ps
module flic_arbiter
  import flic_pkg::*;
#(
  parameter int N = NSRC
) (
  input  wire logic [N-1:0]       req_i,
  input  wire logic [2*N-1:0]     lvl_i,
  output logic                    hit_o,
  output logic [SRC_W-1:0]        idx_o,
  output logic [LVL_W-1:0]        lvl_o
);
  // Scan high index downward so lower index wins on equal level
  always_comb begin
    hit_o = 1'b0;
    idx_o = '0;
    lvl_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i] && (!hit_o || lvl_i[2*i +: 2] >= lvl_o)) begin
        hit_o = 1'b1;
        idx_o = SRC_W'(i);
        lvl_o = lvl_i[2*i +: 2];
      end
    end
  end
endmodule

//--- testbench/flic_sva.sv
// Purpose: Port assertions for flic_top
// Assumes: One clock, async active-high reset
// Notes:   Shadows enable and mask writes seen on the bus
`timescale 1ns/1ps
module flic_sva
  import flic_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic [3:0]       addr_i,
  input wire logic [7:0]       wdata_i,
  input wire logic             wr_i,
  input wire logic             rd_i,
  input wire logic [7:0]       rdata_o,
  input wire logic             boundary_i,
  input wire logic             sleeping_i,
  input wire logic             vec_valid_o,
  input wire logic [SRC_W-1:0] vec_idx_o,
  input wire logic             wake_o,
  input wire logic             irq_o
);
  logic [15:0] en_reg;
  logic [15:0] en_dly_reg;
  logic [7:0]  mask_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow copies of enables and mask
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg     <= 16'h0000;
      en_dly_reg <= 16'h0000;
      mask_reg   <= 8'h00;
    end else begin
      en_dly_reg <= en_reg;
      if (wr_i && addr_i == ADDR_ENA_A) en_reg[7:0] <= wdata_i;
      if (wr_i && addr_i == ADDR_ENA_B) en_reg[15:8] <= wdata_i;
      if (wr_i && addr_i == ADDR_MASK) mask_reg <= wdata_i;
    end
  end
  vec_after_bnd_a: assert property (vec_valid_o |-> $past(boundary_i))
    else $error("vector without boundary");
  vec_range_a: assert property (vec_valid_o |-> vec_idx_o < 4'hF)
    else $error("vector index out of range");
  vec_hold_a: assert property (!vec_valid_o |-> $stable(vec_idx_o))
    else $error("vector index moved");
  en_block_a: assert property (vec_valid_o |-> en_dly_reg[vec_idx_o + {3'h0, vec_idx_o > 4'h6}])
    else $error("disabled source vectored");
  gate_block_a: assert property (vec_valid_o |-> $past(en_reg[GATE_BIT]))
    else $error("vector with gate closed");
  wake_cause_a: assert property (wake_o |-> $past(sleeping_i) && $past(en_reg[GATE_BIT]))
    else $error("wake while awake or gated");
  irq_mask_a: assert property (irq_o |-> $past(mask_reg) != 8'h00)
    else $error("interrupt with mask clear");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
endmodule
bind flic_top flic_sva flic_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .boundary_i(boundary_i), .sleeping_i(sleeping_i),
  .vec_valid_o(vec_valid_o), .vec_idx_o(vec_idx_o), .wake_o(wake_o), .irq_o(irq_o));

//--- testbench/flic_core_model.sv
// Purpose: Core-side model issuing boundaries and returns
// Assumes: Bench requests are one-cycle pulses
// Notes:   No boundaries while asleep, as a halted core
`timescale 1ns/1ps
module flic_core_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic bnd_req_i,
  input  wire logic ret_req_i,
  input  wire logic sleep_req_i,
  input  wire logic wake_i,
  output logic      boundary_o,
  output logic      reti_o,
  output logic      sleeping_o
);
  // Pulses one cycle after each request, boundaries only while awake; sleep ends on wake
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boundary_o <= 1'b0;
      reti_o     <= 1'b0;
      sleeping_o <= 1'b0;
    end else begin
      boundary_o <= bnd_req_i && !sleeping_o;
      reti_o     <= ret_req_i;
      if (wake_i) begin
        sleeping_o <= 1'b0;
      end else if (sleep_req_i) begin
        sleeping_o <= 1'b1;
      end
    end
  end
endmodule

//--- testbench/flic_top_tb.sv
// Purpose: Self-checking bench for flic_top
// Assumes: Core model makes boundary and return pulses
// Notes:   Reset reads first, then table rows, then hand-written cases
`timescale 1ns/1ps
module flic_top_tb
  import flic_pkg::*;
;
  typedef struct packed {
    logic [7:0]  ea;
    logic [7:0]  eb;
    logic [7:0]  lla;
    logic [7:0]  lha;
    logic [14:0] rq;
    logic [4:0]  ex;
  } flic_row_t;
  logic             clk_i, rst_i, wr, rd, bnd_req, ret_req, slp_req;
  logic             boundary, reti, sleeping, vv, wake, irq;
  logic [3:0]       addr;
  logic [7:0]       wdata, rdata, d;
  logic [14:0]      req;
  logic [1:0]       pin_n;
  logic [SRC_W-1:0] vidx;
  int               fail_count, num_checks;
  flic_row_t        rows [8] = '{
    '{8'h82, 8'h00, 8'h00, 8'h00, 15'h0002, 5'h11},
    '{8'h02, 8'h00, 8'h00, 8'h00, 15'h0002, 5'h00},
    '{8'h80, 8'h00, 8'h00, 8'h00, 15'h0002, 5'h00},
    '{8'h8A, 8'h00, 8'h00, 8'h00, 15'h000A, 5'h11},
    '{8'h8A, 8'h00, 8'h08, 8'h00, 15'h000A, 5'h13},
    '{8'h80, 8'h81, 8'h00, 8'h00, 15'h4080, 5'h17},
    '{8'hC2, 8'h00, 8'h00, 8'h40, 15'h0042, 5'h16},
    '{8'hC2, 8'h00, 8'h02, 8'h42, 15'h0042, 5'h11}};
  flic_top flic_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .periph_req_i(req), .ext_irq_pin_n_i(pin_n), .boundary_i(boundary),
    .reti_i(reti), .sleeping_i(sleeping), .vec_valid_o(vv), .vec_idx_o(vidx), .wake_o(wake), .irq_o(irq));
  flic_core_model flic_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .bnd_req_i(bnd_req),
    .ret_req_i(ret_req), .sleep_req_i(slp_req), .wake_i(wake), .boundary_o(boundary), .reti_o(reti),
    .sleeping_o(sleeping));
  // Compare and count
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Register bus cycles
  task wrr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task rdr(input logic [3:0] a);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Raise requests, give a boundary, check the vector
  task vec(input logic [14:0] rq, input logic [4:0] ex);
    @(posedge clk_i);
    req <= rq;
    repeat (5) @(posedge clk_i);
    bnd_req <= 1'b1;
    @(posedge clk_i);
    bnd_req <= 1'b0;
    @(posedge clk_i);
    #1 chk({3'h0, vv, vidx & {4{vv}}}, {3'h0, ex});
  endtask
  task ret;
    @(posedge clk_i);
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task nap_wake;
    int n;
    @(posedge clk_i);
    slp_req <= 1'b1;
    @(posedge clk_i);
    slp_req <= 1'b0;
    n = 0;
    while (wake !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk({7'h0, wake}, 8'h01);
    if (n == 20) print_verdict();
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
  initial begin
    {rst_i, wr, rd, bnd_req, ret_req, slp_req} = 6'h20;
    {addr, wdata, req, pin_n} = {4'h0, 8'h00, 15'h0000, 2'h3};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wrr(4'hF, 8'hFF);
    for (int a = 0; a < 16; a++) begin
      rdr(a[3:0]);
      chk(d, RST_BYTE);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      wrr(ADDR_ENA_A, rows[i].ea);
      wrr(ADDR_ENA_B, rows[i].eb);
      wrr(ADDR_LVL_LO_A, rows[i].lla);
      wrr(ADDR_LVL_HI_A, rows[i].lha);
      vec(rows[i].rq, rows[i].ex);
      ret();
      req <= '0;
    end
    $display("table test done");
    wrr(ADDR_ENA_A, 8'hAA);
    wrr(ADDR_LVL_LO_A, 8'h28);
    wrr(ADDR_LVL_HI_A, 8'h20);
    wrr(ADDR_STAT, 8'h07);
    wrr(ADDR_MASK, 8'h01);
    vec(15'h0008, 5'h13);
    vec(15'h000A, 5'h00);
    chk({7'h0, irq}, 8'h01);
    vec(15'h002A, 5'h15);
    vec(15'h002A, 5'h00);
    ret();
    vec(15'h000A, 5'h00);
    ret();
    vec(15'h000A, 5'h13);
    ret();
    wrr(ADDR_STAT, 8'h07);
    repeat (3) @(posedge clk_i);
    #1 chk({7'h0, irq}, 8'h00);
    $display("preempt test done");
    wrr(ADDR_ENA_A, 8'h80);
    wrr(ADDR_ENA_B, 8'h81);
    wrr(ADDR_LVL_HI_B, 8'h80);
    rdr(ADDR_LVL_HI_B);
    chk(d, 8'h80);
    vec(15'h4080, 5'h1E);
    ret();
    wrr(ADDR_MASK, 8'h00);
    repeat (3) @(posedge clk_i);
    #1 chk({7'h0, irq}, 8'h00);
    $display("level b test done");
    req <= '0;
    wrr(ADDR_TEC, 8'h01);
    wrr(ADDR_ENA_A, 8'h81);
    pin_n <= 2'b10;
    d = 8'h00;
    for (int n = 0; n < 12 && !d[TEC_IE0]; n++) rdr(ADDR_TEC);
    chk(d & 8'h02, 8'h02);
    if (d[TEC_IE0] !== 1'b1) print_verdict();
    vec('0, 5'h10);
    rdr(ADDR_TEC);
    chk(d & 8'h02, 8'h00);
    ret();
    vec('0, 5'h00);
    pin_n <= 2'b11;
    wrr(ADDR_TEC, 8'h00);
    wrr(ADDR_ENA_A, 8'h84);
    pin_n <= 2'b01;
    vec('0, 5'h12);
    ret();
    pin_n <= 2'b11;
    vec('0, 5'h00);
    $display("pin test done");
    pin_n <= 2'b01;
    nap_wake();
    pin_n <= 2'b11;
    wrr(ADDR_ENA_A, 8'h82);
    req <= 15'h0002;
    nap_wake();
    $display("wake test done");
    print_verdict();
  end
endmodule
